// ===== hdl/tlp_id_route_byte_enable_logic.sv
// receive decode and transmit build of id routing fields and byte masks
// assumes headers arrive whole in one cycle, synchronous to i_clk_sys
`timescale 1ns/1ps

module tlp_id_route_byte_enable_logic
	import tlp_route_pkg::*;
(
	// clock, reset, enable
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic         i_clk_en,
	// configuration
	input  wire logic         i_be_check_en,
	input  wire logic [7:0]   i_own_bus,
	input  wire logic [4:0]   i_own_dev,
	input  wire logic [2:0]   i_own_func,
	// receive header from the link port
	input  wire logic         i_rx_valid,
	input  wire logic [127:0] i_rx_hdr,
	// decoded request to the completion logic
	output logic              o_req_valid,
	output pkt_kind_e         o_req_kind,
	output logic              o_req_write,
	output logic              o_req_4dw,
	output logic [63:0]       o_req_addr,
	output logic [7:0]        o_req_bus,
	output logic [4:0]        o_req_dev,
	output logic [2:0]        o_req_func,
	output logic              o_id_match,
	output logic [10:0]       o_req_len_dw,
	output logic [3:0]        o_first_mask,
	output logic [3:0]        o_final_mask,
	output logic              o_wr_noop,
	output logic              o_rd_zero,
	output logic [10:0]       o_cpl_len_dw,
	// error reporting
	output logic              o_malformed,
	// transmit header request
	input  wire logic         i_tx_valid,
	input  wire logic         i_tx_has_data,
	input  wire logic         i_tx_fmt_4dw,
	input  wire logic [4:0]   i_tx_type,
	input  wire logic [7:0]   i_tx_b1,
	input  wire logic [5:0]   i_tx_b2_hi,
	input  wire logic [9:0]   i_tx_len,
	input  wire logic [31:0]  i_tx_b4_7,
	input  wire logic [3:0]   i_tx_first_mask,
	input  wire logic [3:0]   i_tx_final_mask,
	input  wire logic [7:0]   i_tx_bus,
	input  wire logic [4:0]   i_tx_dev,
	input  wire logic [2:0]   i_tx_func,
	input  wire logic [15:0]  i_tx_b10_11,
	input  wire logic [31:0]  i_tx_b12_15,
	// transmit header to the link port
	output logic              o_tx_valid,
	output logic [127:0]      o_tx_hdr
);

	// ==========================================================
	// receive field extraction
	wire [4:0]  rx_type     = i_rx_hdr[TYPE_MSB:TYPE_LSB];
	wire        rx_has_data = i_rx_hdr[FMT_DATA_BIT];
	wire        rx_4dw      = i_rx_hdr[FMT_4DW_BIT];
	wire [9:0]  rx_len      = i_rx_hdr[LEN_MSB:LEN_LSB];
	wire [3:0]  rx_first    = i_rx_hdr[FIRST_MSB:FIRST_LSB];
	wire [3:0]  rx_final    = i_rx_hdr[FINAL_MSB:FINAL_LSB];
	wire [7:0]  rx_bus      = i_rx_hdr[BUS_MSB:BUS_LSB];
	wire [4:0]  rx_dev      = i_rx_hdr[DEV_MSB:DEV_LSB];
	wire [2:0]  rx_func     = i_rx_hdr[FUNC_MSB:FUNC_LSB];

	// type classes
	wire is_mem    = (rx_type == TYPE_MEM) || (rx_type == TYPE_MEM_LK);
	wire is_io     = (rx_type == TYPE_IO);
	wire is_cfg    = (rx_type == TYPE_CFG0) || (rx_type == TYPE_CFG1);
	wire is_cpl    = (rx_type == TYPE_CPL) || (rx_type == TYPE_CPL_LK);
	wire is_msg_id = (rx_type == TYPE_MSG_ID);
	wire has_be    = is_mem || is_io || is_cfg;
	wire id_routed = is_cfg || is_cpl || is_msg_id;

	// one-hot kind from the type classes
	wire pkt_kind_e kind_dec = is_mem ? KIND_MEM : is_io ? KIND_IO : is_cfg ? KIND_CFG :
		is_cpl ? KIND_CPL : is_msg_id ? KIND_MSG_ID : KIND_NONE;

	// ==========================================================
	// address and length
	// every header address bit kept; narrower systems still see no aliases
	wire [63:0] addr_4dw = {i_rx_hdr[BUS_MSB:ADDR_HI_LSB], i_rx_hdr[ADDR_LO_MSB:2], 2'b00};
	wire [63:0] addr_3dw = {32'h0000_0000, i_rx_hdr[BUS_MSB:ADDR_HI_LSB+2], 2'b00};
	wire [63:0] rx_addr  = rx_4dw ? addr_4dw : addr_3dw;
	wire        qw_align = !rx_addr[2];
	wire [10:0] rx_len_dw = (rx_len == LEN_ENC_MAX) ? LEN_MAX_DW : {1'b0, rx_len};
	wire        len_one   = (rx_len == LEN_ONE);

	// ==========================================================
	// identifier match against our own bus, device, function
	wire id_hit = id_routed && (rx_bus == i_own_bus) && (rx_dev == i_own_dev) &&
		(rx_func == i_own_func);

	// ==========================================================
	// mask checker
	be_chk_if chk_bus ();
	assign chk_bus.len_field  = rx_len;
	assign chk_bus.first      = rx_first;
	assign chk_bus.final_m    = rx_final;
	assign chk_bus.has_be     = has_be;
	assign chk_bus.is_mem     = is_mem;
	assign chk_bus.qw_aligned = qw_align;

	be_rule_checker u_checker (
		.chk (chk_bus.chk)
	);

	// violation only counts when the optional check is switched on
	wire be_viol   = chk_bus.viol_first || chk_bus.viol_final || chk_bus.viol_contig;
	wire malf_nxt  = i_rx_valid && i_be_check_en && be_viol;
	wire accept    = i_rx_valid && !malf_nxt;

	// ==========================================================
	// effective byte masks for the completer
	// only enabled bytes are written or read, so empty reads have no side effects
	wire [3:0] first_eff = has_be ? rx_first : MASK_NONE;
	wire [3:0] final_eff = (has_be && !len_one) ? rx_final : MASK_NONE;
	wire       empty_one = has_be && len_one && (rx_first == MASK_NONE);
	wire       wr_noop   = accept && rx_has_data && empty_one;
	wire       rd_zero   = accept && !rx_has_data && empty_one;
	// reads complete with the requested length, even when nothing is enabled
	wire [10:0] cpl_len  = (has_be && !rx_has_data) ? rx_len_dw : 11'h000;

	// ==========================================================
	// request registers
	logic        req_valid_r;
	pkt_kind_e   req_kind_r;
	logic        req_write_r;
	logic        req_4dw_r;
	logic [63:0] req_addr_r;
	logic [7:0]  req_bus_r;
	logic [4:0]  req_dev_r;
	logic [2:0]  req_func_r;
	logic        id_match_r;
	logic [10:0] req_len_r;
	logic [3:0]  first_r;
	logic [3:0]  final_r;
	logic        wr_noop_r;
	logic        rd_zero_r;
	logic [10:0] cpl_len_r;
	logic        malformed_r;

	// strobe and flags; a malformed packet never raises valid
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			req_valid_r <= 1'b0;
			malformed_r <= 1'b0;
			wr_noop_r   <= 1'b0;
			rd_zero_r   <= 1'b0;
		end
		else if (i_clk_en)
		begin
			req_valid_r <= accept;
			malformed_r <= malf_nxt;
			wr_noop_r   <= wr_noop;
			rd_zero_r   <= rd_zero;
		end
	end

	// identifier and format fields
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			req_kind_r  <= KIND_NONE;
			req_write_r <= 1'b0;
			req_4dw_r   <= 1'b0;
			req_bus_r   <= 8'h00;
			req_dev_r   <= 5'h00;
			req_func_r  <= 3'h0;
			id_match_r  <= 1'b0;
		end
		else if (i_clk_en && i_rx_valid)
		begin
			req_kind_r  <= kind_dec;
			req_write_r <= rx_has_data;
			req_4dw_r   <= rx_4dw;
			req_bus_r   <= rx_bus;
			req_dev_r   <= rx_dev;
			req_func_r  <= rx_func;
			id_match_r  <= id_hit;
		end
	end

	// address, length and masks
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			req_addr_r <= 64'h0000_0000_0000_0000;
			req_len_r  <= 11'h000;
			first_r    <= MASK_NONE;
			final_r    <= MASK_NONE;
			cpl_len_r  <= 11'h000;
		end
		else if (i_clk_en && i_rx_valid)
		begin
			req_addr_r <= rx_addr;
			req_len_r  <= rx_len_dw;
			first_r    <= first_eff;
			final_r    <= final_eff;
			cpl_len_r  <= cpl_len;
		end
	end

	assign o_req_valid  = req_valid_r;
	assign o_req_kind   = req_kind_r;
	assign o_req_write  = req_write_r;
	assign o_req_4dw    = req_4dw_r;
	assign o_req_addr   = req_addr_r;
	assign o_req_bus    = req_bus_r;
	assign o_req_dev    = req_dev_r;
	assign o_req_func   = req_func_r;
	assign o_id_match   = id_match_r;
	assign o_req_len_dw = req_len_r;
	assign o_first_mask = first_r;
	assign o_final_mask = final_r;
	assign o_wr_noop    = wr_noop_r;
	assign o_rd_zero    = rd_zero_r;
	assign o_cpl_len_dw = cpl_len_r;
	assign o_malformed  = malformed_r;

	// ==========================================================
	// transmit header build
	tx_hdr_if tx_bus ();
	assign tx_bus.has_data = i_tx_has_data;
	assign tx_bus.fmt_4dw  = i_tx_fmt_4dw;
	assign tx_bus.pkt_type = i_tx_type;
	assign tx_bus.b1       = i_tx_b1;
	assign tx_bus.b2_hi    = i_tx_b2_hi;
	assign tx_bus.len      = i_tx_len;
	assign tx_bus.b4_7     = i_tx_b4_7;
	assign tx_bus.first    = i_tx_first_mask;
	assign tx_bus.final_m  = i_tx_final_mask;
	assign tx_bus.bus      = i_tx_bus;
	assign tx_bus.dev      = i_tx_dev;
	assign tx_bus.func     = i_tx_func;
	assign tx_bus.b10_11   = i_tx_b10_11;
	assign tx_bus.b12_15   = i_tx_b12_15;
	// completions and messages keep their own byte 7
	assign tx_bus.uses_be  = (i_tx_type == TYPE_MEM) || (i_tx_type == TYPE_MEM_LK) ||
		(i_tx_type == TYPE_IO) || (i_tx_type == TYPE_CFG0) || (i_tx_type == TYPE_CFG1);

	tx_hdr_packer u_packer (
		.tx (tx_bus.pack)
	);

	logic         tx_valid_r;
	logic [127:0] tx_hdr_r;

	// one-cycle header register toward the link port
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			tx_valid_r <= 1'b0;
			tx_hdr_r   <= HDR_RST;
		end
		else if (i_clk_en)
		begin
			tx_valid_r <= i_tx_valid;
			tx_hdr_r   <= i_tx_valid ? tx_bus.hdr : tx_hdr_r;
		end
	end

	assign o_tx_valid = tx_valid_r;
	assign o_tx_hdr   = tx_hdr_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	a_malf_drops: assert property (o_malformed |-> !o_req_valid)
		else $error("malformed packet was also passed on");
	a_malf_pulse: assert property (o_malformed && i_clk_en && !i_rx_valid |=> !o_malformed)
		else $error("malformed pulse longer than one cycle");
	a_first_check: assert property (i_clk_en && i_rx_valid && i_be_check_en && has_be && !len_one &&
		rx_first == 4'h0 |=> o_malformed && !o_req_valid)
		else $error("empty first mask on long request not flagged");
	a_final_ignored: assert property (o_req_valid && o_req_len_dw == 11'h001 |-> o_final_mask == 4'h0)
		else $error("final mask used on one-dword request");
	a_len_max: assert property (i_clk_en && i_rx_valid && rx_len == 10'h000 |=>
		o_req_len_dw == 11'h400)
		else $error("zero length field not read as 1024 dwords");
	a_zero_read: assert property (o_rd_zero |-> o_req_valid && !o_req_write && o_cpl_len_dw == 11'h001 &&
		o_first_mask == 4'h0)
		else $error("empty read not completed with one dword");
	a_zero_write: assert property (o_wr_noop |-> o_req_valid && o_req_write && o_first_mask == 4'h0 &&
		o_final_mask == 4'h0)
		else $error("empty write enables a byte");
	a_id_capture: assert property (i_clk_en && i_rx_valid |=> o_req_bus == $past(i_rx_hdr[63:56]) &&
		o_req_dev == $past(i_rx_hdr[55:51]) && o_req_func == $past(i_rx_hdr[50:48]))
		else $error("id fields not taken from bytes 8 and 9");
	a_addr_full: assert property (i_clk_en && i_rx_valid && rx_4dw |=>
		o_req_addr[63:32] == $past(i_rx_hdr[63:32]))
		else $error("upper address bits dropped");
	a_tx_place: assert property (i_clk_en && i_tx_valid |=> o_tx_valid && o_tx_hdr[63:56] == $past(i_tx_bus) &&
		o_tx_hdr[50:48] == $past(i_tx_func))
		else $error("transmit id misplaced");
	a_tx_masks: assert property (i_clk_en && i_tx_valid && i_tx_type == 5'h00 && i_tx_len == 10'h001 |=>
		o_tx_hdr[71:68] == 4'h0 && o_tx_hdr[67:64] == $past(i_tx_first_mask))
		else $error("transmit byte 7 wrong for one-dword write");

endmodule

// ===== hdl/tlp_route_pkg.sv
// header field layout, packet type codes and kind encoding
// assumes a 128-bit header, byte 0 in bits 127:120, byte 15 in bits 7:0
package tlp_route_pkg;

	// ==========================================================
	// header geometry
	localparam int HDR_W        = 128;
	localparam int FMT_DATA_BIT = 126;
	localparam int FMT_4DW_BIT  = 125;
	localparam int TYPE_MSB     = 124;
	localparam int TYPE_LSB     = 120;
	localparam int LEN_MSB      = 105;
	localparam int LEN_LSB      = 96;
	localparam int FINAL_MSB    = 71;
	localparam int FINAL_LSB    = 68;
	localparam int FIRST_MSB    = 67;
	localparam int FIRST_LSB    = 64;
	localparam int BUS_MSB      = 63;
	localparam int BUS_LSB      = 56;
	localparam int DEV_MSB      = 55;
	localparam int DEV_LSB      = 51;
	localparam int FUNC_MSB     = 50;
	localparam int FUNC_LSB     = 48;
	localparam int ADDR_HI_LSB  = 32;
	localparam int ADDR_LO_MSB  = 31;
	localparam int ADDR_W       = 64;

	// ==========================================================
	// length encoding
	localparam int         LEN_W      = 10;
	localparam int         LEN_DW_W   = 11;
	localparam logic [9:0]  LEN_ONE    = 10'h001;
	localparam logic [9:0]  LEN_TWO    = 10'h002;
	localparam logic [9:0]  LEN_ENC_MAX = 10'h000;
	localparam logic [10:0] LEN_MAX_DW = 11'h400;

	// ==========================================================
	// packet type codes
	localparam logic [4:0] TYPE_MEM    = 5'h00;
	localparam logic [4:0] TYPE_MEM_LK = 5'h01;
	localparam logic [4:0] TYPE_IO     = 5'h02;
	localparam logic [4:0] TYPE_CFG0   = 5'h04;
	localparam logic [4:0] TYPE_CFG1   = 5'h05;
	localparam logic [4:0] TYPE_CPL    = 5'h0A;
	localparam logic [4:0] TYPE_CPL_LK = 5'h0B;
	localparam logic [4:0] TYPE_MSG_ID = 5'h12;

	// ==========================================================
	// reset values
	localparam logic [3:0]   MASK_NONE = 4'h0;
	localparam logic [127:0] HDR_RST   = 128'h0000_0000_0000_0000_0000_0000_0000_0000;

	typedef logic [3:0] byte_mask_t;

	typedef enum logic [5:0] {
		KIND_NONE   = 6'b000001,
		KIND_MEM    = 6'b000010,
		KIND_IO     = 6'b000100,
		KIND_CFG    = 6'b001000,
		KIND_CPL    = 6'b010000,
		KIND_MSG_ID = 6'b100000
	} pkt_kind_e;

endpackage

// ===== hdl/tlp_route_if.sv
// carriers between the header logic top and its two helpers
// assumes the tlp_route_pkg package is compiled first
`timescale 1ns/1ps

// ==========================================================
// byte mask check fields and verdicts
interface be_chk_if;
	logic [9:0] len_field;
	logic [3:0] first;
	logic [3:0] final_m;
	logic       has_be;
	logic       is_mem;
	logic       qw_aligned;
	logic       viol_first;
	logic       viol_final;
	logic       viol_contig;
	modport chk (input len_field, first, final_m, has_be, is_mem, qw_aligned,
		output viol_first, viol_final, viol_contig);
	modport user (output len_field, first, final_m, has_be, is_mem, qw_aligned,
		input viol_first, viol_final, viol_contig);
endinterface

// ==========================================================
// transmit header fields and packed header
interface tx_hdr_if;
	logic         has_data;
	logic         fmt_4dw;
	logic [4:0]   pkt_type;
	logic [7:0]   b1;
	logic [5:0]   b2_hi;
	logic [9:0]   len;
	logic [31:0]  b4_7;
	logic         uses_be;
	logic [3:0]   first;
	logic [3:0]   final_m;
	logic [7:0]   bus;
	logic [4:0]   dev;
	logic [2:0]   func;
	logic [15:0]  b10_11;
	logic [31:0]  b12_15;
	logic [127:0] hdr;
	modport pack (input has_data, fmt_4dw, pkt_type, b1, b2_hi, len, b4_7, uses_be, first, final_m,
		bus, dev, func, b10_11, b12_15, output hdr);
	modport user (output has_data, fmt_4dw, pkt_type, b1, b2_hi, len, b4_7, uses_be, first, final_m,
		bus, dev, func, b10_11, b12_15, input hdr);
endinterface

// ===== hdl/be_rule_checker.sv
// byte mask legality against length and quadword alignment
// assumes its fields are stable in the cycle they are judged
`timescale 1ns/1ps

module be_rule_checker
	import tlp_route_pkg::*;
(
	be_chk_if.chk chk
);

	// ==========================================================
	// length classes
	wire len_one = (chk.len_field == LEN_ONE);
	wire len_two = (chk.len_field == LEN_TWO);

	// two-dword unaligned and three-plus dword memory requests must be packed
	wire contig_req = chk.is_mem && ((len_two && !chk.qw_aligned) || (!len_one && !len_two));

	// leading mask must run up to byte 3, trailing mask must start at byte 0
	wire first_tail_ok = (chk.first == 4'h8) || (chk.first == 4'hC) || (chk.first == 4'hE) ||
		(chk.first == 4'hF);
	wire final_head_ok = (chk.final_m == 4'h1) || (chk.final_m == 4'h3) || (chk.final_m == 4'h7) ||
		(chk.final_m == 4'hF);

	// ==========================================================
	// verdicts; single-dword masks may have holes
	assign chk.viol_first  = chk.has_be && !len_one && (chk.first == MASK_NONE);
	assign chk.viol_final  = chk.has_be && (len_one ? (chk.final_m != MASK_NONE)
		: (chk.final_m == MASK_NONE));
	assign chk.viol_contig = chk.has_be && contig_req && !(first_tail_ok && final_head_ok);

endmodule

// ===== hdl/tx_hdr_packer.sv
// places routing id, length and byte masks into an outgoing header
// assumes the caller registers the packed result
`timescale 1ns/1ps

module tx_hdr_packer
	import tlp_route_pkg::*;
(
	tx_hdr_if.pack tx
);

	// ==========================================================
	// byte 7 and upper dword
	// trailing mask forced clear on one-dword requests so they never carry a trailing mask
	wire [3:0] final_eff = (tx.len == LEN_ONE) ? MASK_NONE : tx.final_m;
	wire [7:0] byte7     = tx.uses_be ? {final_eff, tx.first} : tx.b4_7[7:0];
	wire [31:0] hi_dw    = tx.fmt_4dw ? tx.b12_15 : 32'h0000_0000;

	// ==========================================================
	// same id position for three- and four-dword formats
	assign tx.hdr = {1'b0, tx.has_data, tx.fmt_4dw, tx.pkt_type, tx.b1, tx.b2_hi, tx.len,
		tx.b4_7[31:8], byte7, tx.bus, tx.dev, tx.func, tx.b10_11, hi_dw};

endmodule

// ===== tb/link_peer.sv
// link partner model: hands whole headers to the receive side
// assumes the bench steps it through send on the core clock
`timescale 1ns/1ps

module link_peer
(
	// clock
	input  wire logic    i_clk_sys,
	// header toward the design
	output logic         o_rx_valid,
	output logic [127:0] o_rx_hdr
);
	// ==========================================================
	// idle state at time zero
	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_hdr   = 128'h0;
	end

	// ==========================================================
	// one header per call, one cycle wide
	// requests keep the mask rules unless the bench hands a broken one on purpose
	task automatic send(input logic [127:0] h);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_hdr   <= h;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		o_rx_hdr   <= ~h;  // released lines never keep the old value
	endtask
endmodule

// ===== tb/tlp_id_route_byte_enable_logic_tb.sv
// self-checking bench for the id routing and byte mask header logic
// assumes the design package, interfaces and modules are compiled first
`timescale 1ns/1ps

module tlp_id_route_byte_enable_logic_tb
	import tlp_route_pkg::*;
;
	// ==========================================================
	// clock, stimulus and observed signals
	logic         i_clk_sys = 1'b0;
	logic         i_rst_n   = 1'b0;
	logic         chk_on    = 1'b0;
	logic         clk_en    = 1'b1;
	logic [15:0]  own_id    = 16'h3c55;
	logic         rxv;
	logic [127:0] rxh;
	logic         txv = 1'b0, txd = 1'b0, tx4 = 1'b0;
	logic [4:0]   txt = 5'h00;
	logic [9:0]   txl = 10'h001;
	logic [7:0]   txbe = 8'h00;
	logic [15:0]  txid = 16'h0000;
	logic [29:0]  txm = 30'h0000_0000;
	logic [31:0]  txa = 32'h0000_0000, txc = 32'h0000_0000;
	logic         rv, wr, r4, idm, noop, rdz, mal, tov;
	pkt_kind_e    kind;
	logic [63:0]  addr;
	logic [7:0]   bus;
	logic [4:0]   dev;
	logic [2:0]   fn;
	logic [10:0]  ldw, cdw;
	logic [3:0]   fm, lm;
	logic [127:0] toh;
	int           error_cnt = 0;
	int           total_checks = 0;
	logic [4:0]   ttyp[6] = '{TYPE_CFG0, TYPE_CFG1, TYPE_CPL, TYPE_CPL_LK, TYPE_MSG_ID, TYPE_MEM};
	logic [9:0]   vlen[6] = '{10'h002, 10'h003, 10'h002, 10'h001, 10'h002, 10'h003};
	logic [7:0]   vbe[6]  = '{8'h59, 8'h16, 8'h30, 8'h1f, 8'h0f, 8'h5c};
	logic [31:0]  vad[6]  = '{32'h0000_1004, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000,
		32'h0000_1004};

	// free-running core clock
	always #2 i_clk_sys = ~i_clk_sys;

	link_peer peer (.i_clk_sys(i_clk_sys), .o_rx_valid(rxv), .o_rx_hdr(rxh));

	tlp_id_route_byte_enable_logic dut (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
		.i_be_check_en(chk_on), .i_own_bus(own_id[15:8]), .i_own_dev(own_id[7:3]), .i_own_func(own_id[2:0]),
		.i_rx_valid(rxv), .i_rx_hdr(rxh),
		.o_req_valid(rv), .o_req_kind(kind), .o_req_write(wr), .o_req_4dw(r4), .o_req_addr(addr),
		.o_req_bus(bus), .o_req_dev(dev), .o_req_func(fn), .o_id_match(idm), .o_req_len_dw(ldw),
		.o_first_mask(fm), .o_final_mask(lm), .o_wr_noop(noop), .o_rd_zero(rdz), .o_cpl_len_dw(cdw),
		.o_malformed(mal),
		.i_tx_valid(txv), .i_tx_has_data(txd), .i_tx_fmt_4dw(tx4), .i_tx_type(txt), .i_tx_b1(txm[29:22]),
		.i_tx_b2_hi(txm[21:16]), .i_tx_len(txl), .i_tx_b4_7(txa), .i_tx_first_mask(txbe[3:0]),
		.i_tx_final_mask(txbe[7:4]), .i_tx_bus(txid[15:8]), .i_tx_dev(txid[7:3]), .i_tx_func(txid[2:0]),
		.i_tx_b10_11(txm[15:0]), .i_tx_b12_15(txc),
		.o_tx_valid(tov), .o_tx_hdr(toh)
	);

	// ==========================================================
	// shared tasks
	task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// header builder: byte 7 masks, bytes 8..15 routing or address
	function automatic logic [127:0] mk(input logic w, input logic f4, input logic [4:0] t,
		input logic [9:0] l, input logic [7:0] be, input logic [63:0] b8);
		mk = {1'b0, w, f4, t, 14'h0000, l, 24'h00_0000, be, b8};
	endfunction

	// send one header, then judge the verdict pulse one cycle later
	task automatic rx(input logic [127:0] h, input logic ok);
		peer.send(h);
		#1;
		chk("req_valid", rv, ok);
		chk("malformed", mal, !ok);
	endtask

	// build one header; masks and byte 7 expectation given by the caller
	task automatic tx(input logic d, input logic f4, input logic [4:0] t, input logic [9:0] l,
		input logic [7:0] be, input logic [15:0] id, input logic [31:0] a, input logic [31:0] c,
		input logic [7:0] b7, input logic [29:0] m = 30'h0123_4567);
		@(posedge i_clk_sys);
		{txv, txd, tx4, txt, txl, txbe} <= {1'b1, d, f4, t, l, be};
		{txid, txa, txc, txm} <= {id, a, c, m};
		@(posedge i_clk_sys);
		txv <= 1'b0;
		#1;
		chk("tx_valid", tov, 1'b1);
		chk("tx_hdr", toh, {1'b0, d, f4, t, m[29:16], l, a[31:8], b7, id, m[15:0], f4 ? c : 32'h0000_0000});
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// watchdog: the whole run needs about 90 cycles
	initial
	begin
		repeat (3000) @(posedge i_clk_sys);
		error_cnt++;
		$display("watchdog expired");
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		// every id-routed type matches our id, memory never does
		foreach (ttyp[i])
		begin
			rx(mk(1'b0, 1'b0, ttyp[i], LEN_ONE, 8'h0f, {16'h3c55, 48'h0000_0000_0000}), 1'b1);
			chk("id_match", idm, logic'(i < 5));
		end
		chk("kind", kind, KIND_MEM);
		rx(mk(1'b1, 1'b0, TYPE_CPL, 10'h004, 8'ha5, {16'h3c55, 48'h0000_0000_0000}), 1'b1);
		chk("cpl_first", fm, 4'h0);
		rx(mk(1'b0, 1'b1, TYPE_CFG0, LEN_ONE, 8'h0f, {16'ha7f3, 48'h0000_0000_0000}), 1'b1);
		chk("id_fields", {bus, dev, fn, r4, idm}, {8'ha7, 5'h1e, 3'h3, 1'b1, 1'b0});
		own_id <= 16'ha7f3;
		rx(mk(1'b0, 1'b0, TYPE_CFG1, LEN_ONE, 8'h0f, {16'ha7f3, 48'h0000_0000_0000}), 1'b1);
		chk("id_match_new", {kind, idm}, {KIND_CFG, 1'b1});
		// masks, full address and length decoding with the check on
		chk_on <= 1'b1;
		rx(mk(1'b1, 1'b1, TYPE_MEM, 10'h004, 8'h7e, 64'h8123_4567_89ab_cdef), 1'b1);
		chk("addr64", addr, 64'h8123_4567_89ab_cdec);
		chk("masks", {wr, fm, lm, ldw}, {1'b1, 4'he, 4'h7, 11'h004});
		rx(mk(1'b0, 1'b0, TYPE_MEM, LEN_ONE, 8'h0f, 64'hfedc_ba98_7654_3210), 1'b1);
		chk("addr32", addr, 64'h0000_0000_fedc_ba98);
		rx(mk(1'b1, 1'b0, TYPE_MEM, 10'h000, 8'hff, 64'h0000_2000_0000_0000), 1'b1);
		chk("len1024", {ldw, lm}, {11'h400, 4'hf});
		rx(mk(1'b1, 1'b0, TYPE_MEM, LEN_ONE, 8'h00, 64'h0000_2000_0000_0000), 1'b1);
		chk("wr_noop", {noop, rdz}, 2'b10);
		rx(mk(1'b0, 1'b0, TYPE_IO, LEN_ONE, 8'h00, 64'h0000_2000_0000_0000), 1'b1);
		chk("rd_zero", {noop, rdz, cdw}, {2'b01, 11'h001});
		rx(mk(1'b0, 1'b0, TYPE_MEM, LEN_ONE, 8'h0a, 64'h0000_2000_0000_0000), 1'b1);
		rx(mk(1'b1, 1'b0, TYPE_MEM, LEN_TWO, 8'h59, 64'h0000_1000_0000_0000), 1'b1);
		// broken requests are dropped with a one-cycle error pulse
		foreach (vlen[i])
		begin
			rx(mk(1'b1, 1'b0, TYPE_MEM, vlen[i], vbe[i], {vad[i], 32'h0000_0000}), 1'b0);
			@(posedge i_clk_sys);
			#1;
			chk("mal_drop", {mal, rv}, 2'b00);
		end
		// check off: nothing is refused, final mask still ignored at one dword
		chk_on <= 1'b0;
		rx(mk(1'b1, 1'b0, TYPE_MEM, LEN_TWO, 8'h30, 64'h0000_1000_0000_0000), 1'b1);
		rx(mk(1'b1, 1'b0, TYPE_MEM, LEN_ONE, 8'hf3, 64'h0000_1000_0000_0000), 1'b1);
		chk("final_ign", {fm, lm}, 8'h30);
		// transmit builds
		tx(1'b1, 1'b1, TYPE_MEM, LEN_ONE, 8'hf3, 16'h3c55, 32'h1234_5600, 32'h9abc_def0, 8'h03);
		tx(1'b0, 1'b0, TYPE_CFG0, LEN_ONE, 8'h0f, 16'ha7f3, 32'h0000_0000, 32'h5555_aaaa, 8'h0f);
		tx(1'b0, 1'b0, TYPE_CPL, 10'h004, 8'h12, 16'h0108, 32'haaaa_aa5a, 32'h0000_0000, 8'h5a);
		tx(1'b1, 1'b0, TYPE_MEM, 10'h004, 8'h1f, 16'h3c55, 32'h0000_0000, 32'h0000_0000, 8'h1f, 30'h3fff_0000);
		@(posedge i_clk_sys);
		#1;
		chk("tx_pulse", tov, 1'b0);
		// mid-run reset clears every output, then a header on the first edge after release
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk("rst_out", {rv, mal, tov, noop, rdz, kind, ldw, cdw, addr},
			{5'b00000, KIND_NONE, 22'h00_0000, 64'h0000_0000_0000_0000});
		chk("rst_hdr", toh, HDR_RST);
		i_rst_n <= 1'b1;
		rx(mk(1'b0, 1'b0, TYPE_CFG0, LEN_ONE, 8'h0f, {16'ha7f3, 48'h0000_0000_0000}), 1'b1);
		chk("rst_first", {kind, idm}, {KIND_CFG, 1'b1});
		// enable low stretches the pulse, enable high lets it drop
		clk_en <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		chk("freeze", {rv, fm}, {1'b1, 4'hf});
		clk_en <= 1'b1;
		@(posedge i_clk_sys);
		#1;
		chk("thaw", rv, 1'b0);
		finish_test();
	end
endmodule
